// File: tbd_pkg.sv
// shared constants for the twelve-bit instruction decoder
package tbd_pkg;
  localparam int WORD_W     = 12;
  localparam int FIELD_W    = 3;
  localparam int PAGE_W     = 5;
  localparam int OFFS_W     = 7;
  localparam int STATE_W    = 3;
  // instruction classes (top three bits)
  localparam logic [2:0] OPC_AND  = 3'h0;
  localparam logic [2:0] OPC_TAD  = 3'h1;
  localparam logic [2:0] OPC_ISZ  = 3'h2;
  localparam logic [2:0] OPC_DCA  = 3'h3;
  localparam logic [2:0] OPC_JMS  = 3'h4;
  localparam logic [2:0] OPC_JMP  = 3'h5;
  localparam logic [2:0] OPC_IOT  = 3'h6;
  localparam logic [2:0] OPC_OPR  = 3'h7;
  // field positions inside the instruction word (bit 0 is the lsb)
  localparam int IR_OPC_LSB  = 9;
  localparam int IR_IND_BIT  = 8;
  localparam int IR_PAGE_BIT = 7;
  localparam int IR_DEV_LSB  = 3;
  localparam int IR_DEV_W    = 6;
  localparam int IR_FUNC_W   = 3;
  localparam logic [5:0] DEV_INTERNAL = 6'h00;
  localparam logic [2:0] FUNC_CLEAR   = 3'h7;
  // auto-index window on page zero
  localparam logic [6:0] AUTO_LO = 7'h08;
  localparam logic [6:0] AUTO_HI = 7'h0F;
  // states per machine cycle
  localparam logic [2:0] LEN_5 = 3'h5;
  localparam logic [2:0] LEN_6 = 3'h6;
  localparam logic [2:0] LEN_7 = 3'h7;
  // state slots inside a cycle
  localparam logic [2:0] T_LOAD   = 3'h1;
  localparam logic [2:0] T_LATCH  = 3'h2;
  localparam logic [2:0] T_SEL_A  = 3'h3;
  localparam logic [2:0] T_SEL_B  = 3'h4;
  localparam logic [2:0] T_WR_A   = 3'h5;
  localparam logic [2:0] T_WR_B   = 3'h6;
  localparam logic [2:0] T_CTLCAP = 3'h6;
  // reset values
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [2:0]  T_RESET  = 3'h1;

  typedef enum logic [2:0] {
    TBD_FETCH = 3'h0,
    TBD_INDIR = 3'h1,
    TBD_EXEC1 = 3'h3,
    TBD_EXEC2 = 3'h2,
    TBD_IOA   = 3'h6,
    TBD_IOB   = 3'h7,
    TBD_OPA   = 3'h5,
    TBD_OPB   = 3'h4
  } tbd_cycle_e;
endpackage

// File: tbd_sync.sv
// two-stage synchroniser for pin inputs
module tbd_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_val,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      meta_q <= i_reset_val;
      sync_q <= i_reset_val;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// File: tbd_ea.sv
// direct operand address and auto-index detection
module tbd_ea (
  input  wire logic [11:0] i_instr,
  input  wire logic [11:0] i_cur_addr,
  output logic      [11:0] o_direct_addr,
  output logic             o_auto_index
);
  logic        cur_page_sel;
  logic [6:0]  offs;
  logic [4:0]  page;

  assign offs         = i_instr[tbd_pkg::OFFS_W-1:0];
  assign cur_page_sel = i_instr[tbd_pkg::IR_PAGE_BIT];
  // page number is zero, or the upper five bits of the current address when the page bit is set
  assign page         = cur_page_sel ? i_cur_addr[11:7] : 5'h00;
  assign o_direct_addr = {page, offs};
  assign o_auto_index = !cur_page_sel && i_instr[tbd_pkg::IR_IND_BIT]
                        && (offs >= tbd_pkg::AUTO_LO)
                        && (offs <= tbd_pkg::AUTO_HI);
endmodule

// File: tbd_core.sv
// instruction decode, effective address and cycle sequencing core
module tbd_core (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [11:0] i_bus_data,
  input  wire logic [2:0]  i_instr_field,
  input  wire logic [2:0]  i_data_field,
  input  wire logic        i_transfer_ctl_line_0,
  input  wire logic        i_transfer_ctl_line_1,
  input  wire logic        i_transfer_ctl_line_2,
  input  wire logic        i_skip_request_line_n,
  output logic      [11:0] o_bus_addr,
  output logic      [2:0]  o_field_ext,
  output logic      [11:0] o_bus_data,
  output logic             o_address_latch_strobe,
  output logic             o_mem_read,
  output logic             o_mem_write,
  output logic             o_io_device_select_strobe,
  output logic             o_data_field_select_line,
  output logic             o_fetch_cycle,
  output logic             o_io_execute_cycle_first,
  output logic             o_io_execute_cycle_second,
  output logic             o_memory_reference_class,
  output logic             o_io_transfer_class,
  output logic             o_operate_class,
  output logic      [11:0] o_pc,
  output logic      [11:0] o_ac,
  output logic             o_link
);
  tbd_pkg::tbd_cycle_e cyc_q, cyc_d;
  logic [2:0]  t_q, t_d;
  logic [11:0] pc_q, pc_d;
  logic [11:0] ac_q, ac_d;
  logic        link_q, link_d;
  logic [11:0] ir_q, ir_d;
  logic [11:0] mar_q, mar_d;
  logic [11:0] ea_q, ea_d;
  logic [11:0] data_q, data_d;
  logic [11:0] addr_q, addr_d;
  logic [2:0]  fext_q, fext_d;
  logic [11:0] dev_q, dev_d;
  logic [3:0]  ctl_q, ctl_d;
  logic        auto_q, auto_d;

  logic [3:0]  ctl_sync;
  logic [11:0] direct_addr;
  logic        auto_index;
  logic [2:0]  opc;
  logic        indirect;
  logic [5:0]  dev_code;
  logic [2:0]  dev_func;
  logic [2:0]  len;
  logic        last;
  logic        cyc_read;
  logic        cyc_write;
  logic        dfsel;
  logic [12:0] sum;

  tbd_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_async     ({i_skip_request_line_n, i_transfer_ctl_line_2,
                   i_transfer_ctl_line_1, i_transfer_ctl_line_0}),
    .i_reset_val (4'hF),
    .o_sync      (ctl_sync)
  );

  tbd_ea u_ea (
    .i_instr       (ir_q),
    .i_cur_addr    (mar_q),
    .o_direct_addr (direct_addr),
    .o_auto_index  (auto_index)
  );

  assign opc      = ir_q[11:tbd_pkg::IR_OPC_LSB];
  assign indirect = ir_q[tbd_pkg::IR_IND_BIT];
  // device code bits 3-8, operation bits 0-2
  assign dev_code = ir_q[tbd_pkg::IR_DEV_LSB +: tbd_pkg::IR_DEV_W];
  assign dev_func = ir_q[tbd_pkg::IR_FUNC_W-1:0];

  // cycle length per class
  always_comb begin
    len = tbd_pkg::LEN_5;
    case (cyc_q)
      tbd_pkg::TBD_INDIR: len = auto_q ? tbd_pkg::LEN_6 : tbd_pkg::LEN_5;
      tbd_pkg::TBD_EXEC1: begin
        if (opc == tbd_pkg::OPC_ISZ || opc == tbd_pkg::OPC_DCA || opc == tbd_pkg::OPC_JMS) begin
          len = tbd_pkg::LEN_6;
        end
      end
      tbd_pkg::TBD_IOA: len = tbd_pkg::LEN_7;
      tbd_pkg::TBD_IOB: len = tbd_pkg::LEN_6;
      default: len = tbd_pkg::LEN_5;
    endcase
  end

  assign last = (t_q == len);

  // which cycles touch memory
  always_comb begin
    cyc_read  = 1'b0;
    cyc_write = 1'b0;
    case (cyc_q)
      tbd_pkg::TBD_FETCH: cyc_read = 1'b1;
      tbd_pkg::TBD_INDIR: begin
        cyc_read  = 1'b1;
        cyc_write = auto_q;
      end
      tbd_pkg::TBD_EXEC1: begin
        cyc_read  = (opc == tbd_pkg::OPC_AND) || (opc == tbd_pkg::OPC_TAD)
                    || (opc == tbd_pkg::OPC_ISZ);
        cyc_write = (opc == tbd_pkg::OPC_ISZ) || (opc == tbd_pkg::OPC_DCA)
                    || (opc == tbd_pkg::OPC_JMS);
      end
      default: begin
        cyc_read  = 1'b0;
        cyc_write = 1'b0;
      end
    endcase
  end

  // data field only for indirect and/add/isz/deposit execution
  assign dfsel = indirect && (opc <= tbd_pkg::OPC_DCA)
                 && (cyc_q == tbd_pkg::TBD_EXEC1 || cyc_q == tbd_pkg::TBD_EXEC2);

  assign sum = {1'b0, ac_q} + {1'b0, i_bus_data};

  always_comb begin
    cyc_d  = cyc_q;
    t_d    = last ? tbd_pkg::T_LOAD : 3'(t_q + 3'h1);
    pc_d   = pc_q;
    ac_d   = ac_q;
    link_d = link_q;
    ir_d   = ir_q;
    mar_d  = mar_q;
    ea_d   = ea_q;
    data_d = data_q;
    addr_d = addr_q;
    fext_d = fext_q;
    dev_d  = dev_q;
    ctl_d  = ctl_q;
    auto_d = auto_q;
    case (cyc_q)
      tbd_pkg::TBD_FETCH: begin
        if (t_q == tbd_pkg::T_LOAD) begin
          addr_d = pc_q;
          fext_d = i_instr_field;
          mar_d  = pc_q;
          pc_d   = 12'(pc_q + 12'h001);
        end
        if (t_q == tbd_pkg::T_SEL_B) begin
          ir_d = i_bus_data;
        end
        if (last) begin
          ea_d   = direct_addr;
          auto_d = auto_index;
          case (opc)
            tbd_pkg::OPC_IOT: cyc_d = tbd_pkg::TBD_IOA;
            tbd_pkg::OPC_OPR: cyc_d = tbd_pkg::TBD_OPA;
            default: cyc_d = indirect ? tbd_pkg::TBD_INDIR : tbd_pkg::TBD_EXEC1;
          endcase
        end
      end
      tbd_pkg::TBD_INDIR: begin
        if (t_q == tbd_pkg::T_LOAD) begin
          addr_d = ea_q;
          fext_d = i_instr_field;
        end
        if (t_q == tbd_pkg::T_SEL_B) begin
          data_d = auto_q ? 12'(i_bus_data + 12'h001) : i_bus_data;
        end
        if (last) begin
          ea_d  = data_q;
          cyc_d = tbd_pkg::TBD_EXEC1;
        end
      end
      tbd_pkg::TBD_EXEC1: begin
        if (t_q == tbd_pkg::T_LOAD) begin
          addr_d = ea_q;
          fext_d = dfsel ? i_data_field : i_instr_field;
          if (opc == tbd_pkg::OPC_DCA) begin
            data_d = ac_q;
          end
          if (opc == tbd_pkg::OPC_JMS) begin
            data_d = pc_q;
          end
        end
        if (t_q == tbd_pkg::T_SEL_B) begin
          case (opc)
            tbd_pkg::OPC_AND: ac_d = ac_q & i_bus_data;
            tbd_pkg::OPC_TAD: begin
              ac_d   = sum[11:0];
              link_d = link_q ^ sum[12];
            end
            tbd_pkg::OPC_ISZ: data_d = 12'(i_bus_data + 12'h001);
            default: ac_d = ac_q;
          endcase
        end
        if (last) begin
          cyc_d = tbd_pkg::TBD_FETCH;
          case (opc)
            tbd_pkg::OPC_ISZ: cyc_d = tbd_pkg::TBD_EXEC2;
            tbd_pkg::OPC_DCA: ac_d  = 12'h000;
            tbd_pkg::OPC_JMS: pc_d  = 12'(ea_q + 12'h001);
            tbd_pkg::OPC_JMP: pc_d  = ea_q;
            default: cyc_d = tbd_pkg::TBD_FETCH;
          endcase
        end
      end
      tbd_pkg::TBD_EXEC2: begin
        if (last) begin
          if (data_q == 12'h000) begin
            pc_d = 12'(pc_q + 12'h001);
          end
          cyc_d = tbd_pkg::TBD_FETCH;
        end
      end
      tbd_pkg::TBD_IOA: begin
        if (t_q == tbd_pkg::T_LOAD) begin
          addr_d = ir_q;
          data_d = ac_q;
        end
        if (t_q == tbd_pkg::T_SEL_B) begin
          dev_d = i_bus_data;
        end
        if (t_q == tbd_pkg::T_CTLCAP) begin
          ctl_d = (dev_code == tbd_pkg::DEV_INTERNAL) ? 4'hF : ctl_sync;
        end
        if (last) begin
          cyc_d = tbd_pkg::TBD_IOB;
        end
      end
      tbd_pkg::TBD_IOB: begin
        if (last) begin
          cyc_d = tbd_pkg::TBD_FETCH;
          if (dev_code == tbd_pkg::DEV_INTERNAL) begin
            if (dev_func == tbd_pkg::FUNC_CLEAR) begin
              ac_d   = 12'h000;
              link_d = 1'b0;
            end
          end else if (!ctl_q[2]) begin
            pc_d = ctl_q[1] ? 12'(pc_q + dev_q) : dev_q;
          end else begin
            case (ctl_q[1:0])
              2'h2:    ac_d = 12'h000;
              2'h1:    ac_d = ac_q | dev_q;
              2'h0:    ac_d = dev_q;
              default: ac_d = ac_q;
            endcase
            if (!ctl_q[3]) begin
              pc_d = 12'(pc_q + 12'h001);
            end
          end
        end
      end
      tbd_pkg::TBD_OPA: begin
        if (last) begin
          cyc_d = ir_q[tbd_pkg::IR_IND_BIT] ? tbd_pkg::TBD_OPB : tbd_pkg::TBD_FETCH;
        end
      end
      default: begin
        if (last) begin
          cyc_d = tbd_pkg::TBD_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cyc_q  <= tbd_pkg::TBD_FETCH;
      t_q    <= tbd_pkg::T_RESET;
      pc_q   <= tbd_pkg::PC_RESET;
      ac_q   <= 12'h000;
      link_q <= 1'b0;
      ir_q   <= 12'h000;
      mar_q  <= 12'h000;
      ea_q   <= 12'h000;
      data_q <= 12'h000;
      addr_q <= 12'h000;
      fext_q <= 3'h0;
      dev_q  <= 12'h000;
      ctl_q  <= 4'hF;
      auto_q <= 1'b0;
    end else begin
      cyc_q  <= cyc_d;
      t_q    <= t_d;
      pc_q   <= pc_d;
      ac_q   <= ac_d;
      link_q <= link_d;
      ir_q   <= ir_d;
      mar_q  <= mar_d;
      ea_q   <= ea_d;
      data_q <= data_d;
      addr_q <= addr_d;
      fext_q <= fext_d;
      dev_q  <= dev_d;
      ctl_q  <= ctl_d;
      auto_q <= auto_d;
    end
  end

  // bus strobes decoded from the state slot
  assign o_address_latch_strobe = (t_q == tbd_pkg::T_LATCH)
                                  && (cyc_read || cyc_write || cyc_q == tbd_pkg::TBD_IOA);
  assign o_mem_read  = cyc_read && (t_q == tbd_pkg::T_SEL_A || t_q == tbd_pkg::T_SEL_B);
  assign o_mem_write = cyc_write && (cyc_read ? (t_q == tbd_pkg::T_WR_A || t_q == tbd_pkg::T_WR_B)
                                              : (t_q == tbd_pkg::T_SEL_A || t_q == tbd_pkg::T_SEL_B));
  assign o_io_device_select_strobe = (cyc_q == tbd_pkg::TBD_IOA)
                                     && (dev_code != tbd_pkg::DEV_INTERNAL)
                                     && (t_q == tbd_pkg::T_SEL_A || t_q == tbd_pkg::T_SEL_B);
  assign o_data_field_select_line  = dfsel;
  assign o_fetch_cycle             = (cyc_q == tbd_pkg::TBD_FETCH);
  assign o_io_execute_cycle_first  = (cyc_q == tbd_pkg::TBD_IOA);
  assign o_io_execute_cycle_second = (cyc_q == tbd_pkg::TBD_IOB);
  assign o_memory_reference_class  = (opc <= tbd_pkg::OPC_JMP);
  assign o_io_transfer_class       = (opc == tbd_pkg::OPC_IOT);
  assign o_operate_class           = (opc == tbd_pkg::OPC_OPR);
  assign o_bus_addr  = addr_q;
  assign o_field_ext = fext_q;
  assign o_bus_data  = data_q;
  assign o_pc        = pc_q;
  assign o_ac        = ac_q;
  assign o_link      = link_q;
endmodule

// File: tbd_core_properties.sv
// concurrent checks on the decoder core ports
module tbd_core_properties (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic [2:0]  i_instr_field,
  input wire logic [2:0]  i_data_field,
  input wire logic [11:0] o_bus_addr,
  input wire logic [2:0]  o_field_ext,
  input wire logic        o_address_latch_strobe,
  input wire logic        o_mem_read,
  input wire logic        o_mem_write,
  input wire logic        o_io_device_select_strobe,
  input wire logic        o_data_field_select_line,
  input wire logic        o_fetch_cycle,
  input wire logic        o_io_execute_cycle_first,
  input wire logic        o_io_execute_cycle_second,
  input wire logic        o_memory_reference_class,
  input wire logic        o_io_transfer_class,
  input wire logic        o_operate_class,
  input wire logic [11:0] o_pc
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  a_fetch_slots: assert property (
    $rose(o_fetch_cycle) |-> !o_address_latch_strobe ##1 o_address_latch_strobe
    ##1 (o_mem_read && !o_address_latch_strobe)[*2] ##1 !o_mem_read)
    else $error("fetch strobe or read slots misplaced");
  a_pc_advance: assert property (
    $rose(o_fetch_cycle) |-> ##1 (o_pc == o_bus_addr + 12'h001))
    else $error("counter not one past fetch address");
  a_io_cycle_len: assert property (
    $rose(o_io_execute_cycle_first) |-> o_io_execute_cycle_first[*7]
    ##1 o_io_execute_cycle_second[*6] ##1 o_fetch_cycle)
    else $error("io cycle lengths wrong");
  a_io_select: assert property (
    $rose(o_io_execute_cycle_first) ##1 (o_bus_addr[8:3] != 6'h00) |-> o_address_latch_strobe
    ##1 o_io_device_select_strobe[*2] ##1 !o_io_device_select_strobe)
    else $error("device select slots wrong");
  a_internal_quiet: assert property (
    o_io_device_select_strobe |-> o_io_execute_cycle_first && (o_bus_addr[8:3] != 6'h00))
    else $error("select strobe outside io or for code zero");
  a_one_class: assert property (
    $onehot({o_memory_reference_class, o_io_transfer_class, o_operate_class}))
    else $error("instruction class not unique");
  a_io_class: assert property (
    (o_io_execute_cycle_first || o_io_execute_cycle_second) |-> o_io_transfer_class)
    else $error("io cycle without io class");
  a_field_pick: assert property (
    (o_mem_read || o_mem_write) |->
    o_field_ext == (o_data_field_select_line ? i_data_field : i_instr_field))
    else $error("field extension from wrong register");
  a_opr_len: assert property (
    $fell(o_fetch_cycle) && o_operate_class |-> !o_fetch_cycle[*5]
    ##1 (o_fetch_cycle or (!o_fetch_cycle[*5] ##1 o_fetch_cycle)))
    else $error("operate cycle count wrong");
endmodule

bind tbd_core tbd_core_properties tbd_core_properties_inst (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_instr_field(i_instr_field),
  .i_data_field(i_data_field), .o_bus_addr(o_bus_addr), .o_field_ext(o_field_ext),
  .o_address_latch_strobe(o_address_latch_strobe), .o_mem_read(o_mem_read),
  .o_mem_write(o_mem_write), .o_io_device_select_strobe(o_io_device_select_strobe),
  .o_data_field_select_line(o_data_field_select_line), .o_fetch_cycle(o_fetch_cycle),
  .o_io_execute_cycle_first(o_io_execute_cycle_first),
  .o_io_execute_cycle_second(o_io_execute_cycle_second),
  .o_memory_reference_class(o_memory_reference_class),
  .o_io_transfer_class(o_io_transfer_class), .o_operate_class(o_operate_class),
  .o_pc(o_pc));

// File: tbd_bus_partner.sv
// memory fields, one peripheral and an interface-element responder on the decoder bus
module tbd_bus_partner #(
  parameter logic [5:0] DEV_CODE  = 6'h03,
  parameter logic [4:0] ELEM_CODE = 5'h08
) (
  input  wire logic        i_clock,
  input  wire logic [11:0] i_bus_addr,
  input  wire logic [2:0]  i_field_ext,
  input  wire logic [11:0] i_write_data,
  input  wire logic        i_address_latch_strobe,
  input  wire logic        i_mem_read,
  input  wire logic        i_mem_write,
  input  wire logic        i_io_device_select_strobe,
  input  wire logic        i_fetch_cycle,
  output logic      [11:0] o_bus_data,
  output logic             o_transfer_ctl_line_0,
  output logic             o_transfer_ctl_line_1,
  output logic             o_transfer_ctl_line_2,
  output logic             o_skip_request_line_n
);
  logic [11:0] mem [0:32767];
  logic [2:0]  ctl_tab [0:7];
  logic        skip_n_tab [0:7];
  logic [11:0] dat_tab [0:7];
  logic [11:0] cap [0:15];
  int          n_cap = 0;
  logic [14:0] lat_a = 15'h0000;
  logic [11:0] last_q = 12'h000;
  logic        sel_q = 1'b0;
  logic        active;
  logic        elem;

  // respond only to own device code, from select until the next fetch
  assign active = (lat_a[8:3] == DEV_CODE) && (i_io_device_select_strobe || sel_q);
  // interface-element responder: 5-bit select code, 4-bit op, jam-loads the op as data
  assign elem = (lat_a[8:4] == ELEM_CODE) && (i_io_device_select_strobe || sel_q);
  assign o_transfer_ctl_line_0 = active ? ctl_tab[lat_a[2:0]][0] : !elem;
  assign o_transfer_ctl_line_1 = active ? ctl_tab[lat_a[2:0]][1] : !elem;
  assign o_transfer_ctl_line_2 = active ? ctl_tab[lat_a[2:0]][2] : 1'b1;
  assign o_skip_request_line_n = active ? skip_n_tab[lat_a[2:0]] : 1'b1;

  always_comb begin
    if (i_mem_read) begin
      o_bus_data = mem[lat_a];
    end else if (active && i_io_device_select_strobe) begin
      o_bus_data = dat_tab[lat_a[2:0]];
    end else if (elem && i_io_device_select_strobe) begin
      o_bus_data = {8'h00, lat_a[3:0]};
    end else begin
      o_bus_data = ~last_q;
    end
  end

  always @(posedge i_clock) begin
    last_q <= o_bus_data;
    if (i_address_latch_strobe) begin
      lat_a <= {i_field_ext, i_bus_addr};
    end
    if (i_mem_write) begin
      mem[lat_a] <= i_write_data;
    end
    if (i_io_device_select_strobe && !sel_q) begin
      cap[n_cap[3:0]] <= i_write_data;
      n_cap <= n_cap + 1;
    end
    sel_q <= i_fetch_cycle ? 1'b0 : (sel_q || i_io_device_select_strobe);
  end
endmodule

// File: test_twelve_bit_instruction_decode.sv
// self-checking bench for the decoder core against a bus partner
module test_twelve_bit_instruction_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0;
  logic        i_nrst = 1'b0;
  logic [2:0]  i_instr_field = 3'h0;
  logic [2:0]  i_data_field = 3'h0;
  logic [11:0] rdata, wdata, addr, pc, ac;
  logic [2:0]  fext;
  logic        c0, c1, c2, skip_n, latch, rd, wr, sel, fetch, link;
  int          mismatches = 0;
  int          total_checks = 0;

  always #50 i_clock = ~i_clock;

  tbd_core tbd_core_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_bus_data(rdata),
    .i_instr_field(i_instr_field), .i_data_field(i_data_field),
    .i_transfer_ctl_line_0(c0), .i_transfer_ctl_line_1(c1),
    .i_transfer_ctl_line_2(c2), .i_skip_request_line_n(skip_n),
    .o_bus_addr(addr), .o_field_ext(fext), .o_bus_data(wdata),
    .o_address_latch_strobe(latch), .o_mem_read(rd), .o_mem_write(wr),
    .o_io_device_select_strobe(sel), .o_data_field_select_line(),
    .o_fetch_cycle(fetch), .o_io_execute_cycle_first(), .o_io_execute_cycle_second(),
    .o_memory_reference_class(), .o_io_transfer_class(), .o_operate_class(),
    .o_pc(pc), .o_ac(ac), .o_link(link));

  tbd_bus_partner tbd_bus_partner_inst (
    .i_clock(i_clock), .i_bus_addr(addr), .i_field_ext(fext), .i_write_data(wdata),
    .i_address_latch_strobe(latch), .i_mem_read(rd), .i_mem_write(wr),
    .i_io_device_select_strobe(sel), .i_fetch_cycle(fetch), .o_bus_data(rdata),
    .o_transfer_ctl_line_0(c0), .o_transfer_ctl_line_1(c1),
    .o_transfer_ctl_line_2(c2), .o_skip_request_line_n(skip_n));

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] m(input logic [14:0] a);
    return tbd_bus_partner_inst.mem[a];
  endfunction

  task automatic load(input logic [14:0] base, input logic [11:0] w[]);
    foreach (w[i]) tbd_bus_partner_inst.mem[base + 15'(i)] = w[i];
  endtask

  task automatic set_dev(input logic [2:0] f, input logic [2:0] ctl, input logic skn,
                         input logic [11:0] d);
    tbd_bus_partner_inst.ctl_tab[f] = ctl;
    tbd_bus_partner_inst.skip_n_tab[f] = skn;
    tbd_bus_partner_inst.dat_tab[f] = d;
  endtask

  // reset, wait for bus writes to settle, then blank all fields
  task automatic start(input logic [2:0] ifld, input logic [2:0] dfld);
    @(posedge i_clock);
    i_nrst <= 1'b0;
    i_instr_field <= ifld;
    i_data_field <= dfld;
    repeat (2) @(posedge i_clock);
    for (int i = 0; i < 32768; i++) tbd_bus_partner_inst.mem[i] = 12'h000;
  endtask

  task automatic release_reset;
    repeat (14) @(posedge i_clock);
    i_nrst <= 1'b1;
  endtask

  // bounded wait for the address phase of a fetch at address a
  task automatic wait_fetch(input logic [11:0] a);
    int n;
    n = 0;
    @(negedge i_clock);
    while (!(fetch === 1'b1 && latch === 1'b1 && addr === a) && n < 3000) begin
      @(negedge i_clock);
      n++;
    end
    check({11'h000, n < 3000}, 12'h001);
  endtask

  task automatic test_memory_ops;
    start(3'h0, 3'h1);
    load(15'h0000, '{12'hB08});
    load(15'h0008, '{12'h07F});
    load(15'h0030, '{12'h100, 12'h003, 12'h000, 12'h123, 12'h555});
    load(15'h0040, '{12'hFFF});
    load(15'h0080, '{12'h240, 12'h2B0, 12'h031, 12'h6B1, 12'h4B2, 12'h634, 12'h8C0});
    load(15'h00B0, '{12'h002, 12'h000, 12'hFFF});
    load(15'h00C1, '{12'h231, 12'h733, 12'hAC3});
    load(15'h0123, '{12'h777});
    release_reset;
    wait_fetch(12'h0C3);
    check(ac, 12'h000);
    check({11'h000, link}, 12'h001);
    check(m(15'h00B1), 12'h001);
    check(m(15'h00B2), 12'h000);
    check(m(15'h0034), 12'h555);
    check(m(15'h00C0), 12'h087);
    check(m(15'h0008), 12'h080);
    check(m(15'h1123), 12'h003);
    check(m(15'h0123), 12'h777);
    $display("memory reference test done");
  endtask

  task automatic test_io_transfers;
    time t0;
    start(3'h0, 3'h0);
    load(15'h0000, '{12'h240, 12'hC19, 12'hC1B, 12'hC1A, 12'hC18, 12'hC1B, 12'hC18,
                     12'h241, 12'hC07, 12'hC1C});
    load(15'h001A, '{12'hC1D});
    load(15'h0030, '{12'hE00, 12'hF00, 12'hC85, 12'hA33});
    load(15'h0040, '{12'h00F, 12'hFFF});
    set_dev(3'h0, 3'h7, 1'b1, 12'h000);
    set_dev(3'h1, 3'h5, 1'b0, 12'h5A0);
    set_dev(3'h2, 3'h6, 1'b1, 12'h000);
    set_dev(3'h3, 3'h4, 1'b1, 12'h123);
    set_dev(3'h4, 3'h2, 1'b1, 12'h010);
    set_dev(3'h5, 3'h0, 1'b1, 12'h030);
    release_reset;
    wait_fetch(12'h030);
    check(tbd_bus_partner_inst.cap[0], 12'h00F);
    check(tbd_bus_partner_inst.cap[1], 12'h5AF);
    check(tbd_bus_partner_inst.cap[2], 12'h000);
    check(tbd_bus_partner_inst.cap[4], 12'h123);
    check(12'(tbd_bus_partner_inst.n_cap), 12'h007);
    check(ac, 12'h000);
    check({11'h000, link}, 12'h000);
    t0 = $time;
    wait_fetch(12'h032);
    check(12'(($time - t0) / 100), 12'h019);
    wait_fetch(12'h033);
    check(ac, 12'h005);
    $display("io transfer test done");
  endtask

  task automatic test_wrap_fields;
    start(3'h2, 3'h0);
    load(15'h2000, '{12'hB0A});
    load(15'h200A, '{12'hFFE});
    load(15'h2040, '{12'h007});
    load(15'h2FFF, '{12'h240});
    release_reset;
    wait_fetch(12'hFFF);
    check(pc, 12'h000);
    check({9'h000, fext}, 12'h002);
    wait_fetch(12'h000);
    check(ac, 12'h007);
    check(m(15'h200A), 12'hFFF);
    wait_fetch(12'h000);
    check(m(15'h200A), 12'h000);
    check(ac, 12'h007);
    $display("wrap and field test done");
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    test_memory_ops;
    test_io_transfers;
    test_wrap_fields;
    tally_and_finish;
  end

  initial begin
    #(100 * 20000);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
